// [core/io_port_watchdog_timer.sv]
// Purpose: Watchdog timer steered by one write-only byte port
// Assumes: Host write strobe and bus are asynchronous and held stable
// Notes: Expiry gives a reset pulse or holds the IRQ15 level
`timescale 1ns/1ps
`default_nettype none
module io_port_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT,
   parameter int unsigned BLINK_CYCLES = BLINK_CYCLES_DFLT
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,

   // Host I/O write port
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic [IO_DATA_W-1:0] io_data,
   input wire logic io_wr_n,

   // Expiry actions
   output logic sys_reset_out,
   output logic irq15_out,

   // Indicators
   output logic led_out,
   output logic wdt_active
);

   // Synchronised host bus
   io_write_t bus_pin;
   io_write_t bus_lvl;

   assign bus_pin.wr_n = io_wr_n;
   assign bus_pin.addr = io_addr;
   assign bus_pin.data = io_data;

   pin_sync3 #(
      .W($bits(io_write_t)),
      .RST_VAL(IO_IDLE)
   ) u_bus_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_in(bus_pin),
      .level_out(bus_lvl)
   );

   // Filtered fields by name; raw pins are never read past this point
   wire lvl_wr_n;
   wire [IO_ADDR_W-1:0] lvl_addr;
   wire [IO_DATA_W-1:0] lvl_data;

   assign lvl_wr_n = bus_lvl.wr_n;
   assign lvl_addr = bus_lvl.addr;
   assign lvl_data = bus_lvl.data;

   // State and registers
   state_t state_reg;
   state_t state_next;
   factor_t factor_reg;
   factor_t factor_next;
   logic wr_prev_reg;
   logic [TICK_W-1:0] tick_cnt_reg;
   logic [TICK_W-1:0] tick_cnt_next;
   logic [ELAPSED_W-1:0] elapsed_reg;
   logic [ELAPSED_W-1:0] elapsed_next;
   logic [PULSE_W-1:0] pulse_cnt_reg;
   logic [PULSE_W-1:0] pulse_cnt_next;
   logic [BLINK_W-1:0] blink_cnt_reg;
   logic [BLINK_W-1:0] blink_cnt_next;
   logic led_reg;
   logic led_next;
   logic sys_reset_reg;
   logic irq15_reg;
   logic active_reg;
   logic sys_reset_next;
   logic irq15_next;
   logic active_next;

   // Write decode
   wire wr_edge;
   wire wr_hit;
   wire reset_busy;
   wire wr_accept;
   wire factor_t wr_factor;
   wire wr_enable;
   wire wr_disable;

   // Latch on the rising edge so data has long settled
   assign wr_edge = lvl_wr_n & ~wr_prev_reg;
   assign wr_hit = wr_edge & (lvl_addr == CTRL_PORT_ADDR);
   // A reset pulse in flight runs to its end
   assign reset_busy = (state_reg == ST_FIRED) & ~factor_reg.irq_mode;
   assign wr_accept = wr_hit & ~reset_busy;
   assign wr_factor = decode_factor(lvl_data);
   assign wr_enable = wr_accept & wr_factor.enable;
   // Clear bit 7 (00H among them) turns the timer off
   assign wr_disable = wr_accept & ~wr_factor.enable;

   // Time base
   wire [TICK_W-1:0] tick_last;
   wire [BLINK_W-1:0] blink_last;
   wire [ELAPSED_W-1:0] limit_ticks;
   wire [ELAPSED_W-1:0] elapsed_inc;
   wire counting;
   wire tick;
   wire expire;
   wire pulse_done;
   wire blink_wrap;

   assign tick_last = TICK_W'(TICK_CYCLES - 1);
   assign blink_last = BLINK_W'(BLINK_CYCLES - 1);
   assign limit_ticks = period_ticks(factor_reg.idx);
   assign elapsed_inc = elapsed_reg + 4'h1;
   assign counting = (state_reg == ST_COUNT);
   assign tick = counting & (tick_cnt_reg == tick_last);
   // A refresh in the same cycle beats the expiry
   assign expire = tick & (elapsed_inc == limit_ticks) & ~wr_accept;
   assign pulse_done = (pulse_cnt_reg == '0);
   assign blink_wrap = (blink_cnt_reg == blink_last);

   // State machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (wr_enable) begin
               state_next = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (wr_disable) begin
               state_next = ST_IDLE;
            end else if (wr_enable) begin
               state_next = ST_COUNT;
            end else if (expire) begin
               state_next = ST_FIRED;
            end
         end
         ST_FIRED: begin
            if (wr_disable) begin
               state_next = ST_IDLE;
            end else if (wr_enable) begin
               state_next = ST_COUNT;
            end else if (reset_busy && pulse_done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Factor in force
   always_comb begin
      factor_next = factor_reg;
      if (wr_enable) begin
         factor_next = wr_factor;
      end else if (wr_disable) begin
         factor_next = FACTOR_RESET;
      end
   end

   // Prescaler and elapsed count, both cleared by any enabling write
   always_comb begin
      tick_cnt_next = tick_cnt_reg;
      elapsed_next = elapsed_reg;
      if (wr_accept || state_next != ST_COUNT) begin
         tick_cnt_next = '0;
         elapsed_next = '0;
      end else if (tick) begin
         tick_cnt_next = '0;
         elapsed_next = elapsed_inc;
      end else begin
         tick_cnt_next = tick_cnt_reg + 28'h0000001;
      end
   end

   // Reset pulse length
   always_comb begin
      pulse_cnt_next = pulse_cnt_reg;
      if (expire) begin
         pulse_cnt_next = PULSE_W'(RESET_PULSE_CYCLES - 1);
      end else if (state_reg == ST_FIRED && !pulse_done) begin
         pulse_cnt_next = pulse_cnt_reg - 12'h001;
      end
   end

   // Blinker, dark whenever not counting
   always_comb begin
      blink_cnt_next = '0;
      led_next = 1'b0;
      if (state_next == ST_COUNT) begin
         led_next = led_reg;
         blink_cnt_next = blink_cnt_reg + 24'h000001;
         if (blink_wrap) begin
            blink_cnt_next = '0;
            led_next = ~led_reg;
         end
      end
   end

   // Registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         factor_reg <= FACTOR_RESET;
      end else begin
         factor_reg <= factor_next;
      end
   end

   // Resets to the idle level, so leaving reset gives no false edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_prev_reg <= 1'b1;
      end else begin
         wr_prev_reg <= lvl_wr_n;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   // Whole ticks only, so a period is exact to one prescaler wrap
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed_reg <= '0;
      end else begin
         elapsed_reg <= elapsed_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_reg <= '0;
      end else begin
         pulse_cnt_reg <= pulse_cnt_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt_reg <= '0;
      end else begin
         blink_cnt_reg <= blink_cnt_next;
      end
   end

   // Dark at once on disable, so a stopped timer never looks alive
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         led_reg <= 1'b0;
      end else begin
         led_reg <= led_next;
      end
   end

   // Actions follow the next state so they line up with it
   assign sys_reset_next = (state_next == ST_FIRED) & ~factor_next.irq_mode;
   assign irq15_next = (state_next == ST_FIRED) & factor_next.irq_mode;
   assign active_next = (state_next == ST_COUNT);

   // Silent from reset until software arms the timer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_reg <= 1'b0;
      end else begin
         sys_reset_reg <= sys_reset_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq15_reg <= 1'b0;
      end else begin
         irq15_reg <= irq15_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= active_next;
      end
   end

   // Outputs
   assign sys_reset_out = sys_reset_reg;
   assign irq15_out = irq15_reg;
   assign led_out = led_reg;
   assign wdt_active = active_reg;

endmodule
`default_nettype wire

// [core/wdt_pkg.sv]
// Purpose: Shared constants, types and decode functions of the port watchdog
// Assumes: 50 MHz mclk, one write-only byte port on a 16-bit I/O address bus
// Notes: Notes on behaviour follow below
package wdt_pkg;

   // Clock
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CLK_MHZ = 50;

   // Port decode
   localparam int unsigned IO_ADDR_W = 16;
   localparam int unsigned IO_DATA_W = 8;
   localparam logic [IO_ADDR_W-1:0] CTRL_PORT_ADDR = 16'h0076;

   // Factor byte layout and values
   localparam int unsigned FACTOR_EN_BIT = 7;
   localparam int unsigned FACTOR_IRQ_BIT = 6;
   localparam int unsigned FACTOR_IDX_MSB = 2;
   localparam int unsigned FACTOR_IDX_LSB = 0;
   localparam logic [IO_DATA_W-1:0] FACTOR_DISABLE = 8'h00;

   // Timing
   localparam int unsigned SHORT_PERIOD_S = 3;
   localparam int unsigned TIMEOUT_UNIT_S = 6;
   localparam int unsigned TICK_CYCLES_DFLT = SHORT_PERIOD_S * CLK_HZ;
   localparam int unsigned BLINK_MS = 250;
   localparam int unsigned BLINK_CYCLES_DFLT = BLINK_MS * (CLK_HZ / 1000);
   localparam int unsigned RESET_PULSE_US = 20;
   localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_US * CLK_MHZ;

   // Counter widths
   localparam int unsigned TICK_W = 28;
   localparam int unsigned BLINK_W = 24;
   localparam int unsigned ELAPSED_W = 4;
   localparam int unsigned PULSE_W = 12;

   typedef struct packed {
      logic enable;
      logic irq_mode;
      logic [2:0] idx;
   } factor_t;

   localparam factor_t FACTOR_RESET = 5'h00;

   typedef struct packed {
      logic wr_n;
      logic [IO_ADDR_W-1:0] addr;
      logic [IO_DATA_W-1:0] data;
   } io_write_t;

   localparam io_write_t IO_IDLE = 25'h1000000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_COUNT = 3'b010,
      ST_FIRED = 3'b100
   } state_t;

   function automatic factor_t decode_factor(input logic [IO_DATA_W-1:0] b);
      factor_t f;
      f.enable = b[FACTOR_EN_BIT];
      f.irq_mode = b[FACTOR_IRQ_BIT];
      f.idx = b[FACTOR_IDX_MSB:FACTOR_IDX_LSB];
      return f;
   endfunction

   // Period in ticks of SHORT_PERIOD_S: 1,2,4,6,...,14
   function automatic logic [ELAPSED_W-1:0] period_ticks(input logic [2:0] idx);
      int unsigned t;
      t = 32'(idx) * TIMEOUT_UNIT_S / SHORT_PERIOD_S;
      if (idx == 3'h0) begin
         t = 1;
      end
      return ELAPSED_W'(t);
   endfunction

endpackage

// [core/pin_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes: Output follows only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Pins and filtered levels
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] level_reg;

   // First stage feeds the second only
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               level_reg[i] <= RST_VAL[i];
            end else if (s2_reg[i] == s3_reg[i]) begin
               level_reg[i] <= s3_reg[i];
            end
         end
      end
   endgenerate

   assign level_out = level_reg;

endmodule
`default_nettype wire

// [tb/wdt_port_assertions.sv]
// Purpose: Port checks of the watchdog
// Assumes: Short tick count
// Notes: Bind at the foot
`timescale 1ns/1ps
`default_nettype none
module wdt_port_assertions
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 20,
   parameter int unsigned BLINK_CYCLES = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Host port
   input wire logic [IO_ADDR_W-1:0] io_addr,
   input wire logic [IO_DATA_W-1:0] io_data,
   input wire logic io_wr_n,
   // Outputs
   input wire logic sys_reset_out,
   input wire logic irq15_out,
   input wire logic led_out,
   input wire logic wdt_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire logic hit = io_addr == CTRL_PORT_ADDR;
   logic [15:0] pulse_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) pulse_reg <= 16'h0;
      else pulse_reg <= sys_reset_out ? pulse_reg + 16'h1 : 16'h0;
   end
   // Longest legal run: seven units plus the write latency
   localparam int unsigned LONGEST = 32'h7 * TIMEOUT_UNIT_S / SHORT_PERIOD_S * TICK_CYCLES + 32'h8;
   logic led_prev_reg;
   logic [15:0] still_reg;
   logic [31:0] run_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         led_prev_reg <= 1'b0;
         still_reg <= 16'h0;
         run_reg <= 32'h0;
      end else begin
         led_prev_reg <= led_out;
         still_reg <= (wdt_active && led_out == led_prev_reg) ? still_reg + 16'h1 : 16'h0;
         run_reg <= (wdt_active && io_wr_n) ? run_reg + 32'h1 : 32'h0;
      end
   end
   AST_RESET_QUIET: assert property (
      !$past(rst_n) |-> !(wdt_active || led_out || sys_reset_out || irq15_out))
      else $error("busy after reset");
   AST_ENABLE: assert property (
      $rose(io_wr_n) && hit && io_data[7] && !sys_reset_out |-> ##8 wdt_active && !irq15_out)
      else $error("enable lost");
   AST_DISABLE: assert property (
      $rose(io_wr_n) && hit && !io_data[7] |-> ##8 !(wdt_active || led_out || irq15_out))
      else $error("disable lost");
   AST_OTHER_PORT: assert property (
      $rose(io_wr_n) && !hit && !wdt_active |-> ##8 !wdt_active)
      else $error("stray port taken");
   AST_RESET_EXPIRY: assert property (
      $rose(sys_reset_out) |-> $fell(wdt_active) && !irq15_out)
      else $error("stray reset");
   AST_IRQ_EXPIRY: assert property (
      $rose(irq15_out) |-> $fell(wdt_active) && !sys_reset_out)
      else $error("stray irq");
   AST_PULSE_LEN: assert property (
      $fell(sys_reset_out) |-> pulse_reg == RESET_PULSE_CYCLES)
      else $error("pulse length");
   AST_LED_IDLE: assert property (!wdt_active |-> !led_out)
      else $error("led while idle");
   AST_LED_BLINK: assert property (
      still_reg <= 16'(BLINK_CYCLES))
      else $error("led not blinking");
   AST_EXPIRY_BOUND: assert property (
      run_reg <= LONGEST)
      else $error("never expired");
   cover property ($rose(sys_reset_out));
   cover property ($rose(irq15_out));
   cover property ($rose(wdt_active));
endmodule
bind io_port_watchdog_timer wdt_port_assertions #(
   .TICK_CYCLES(TICK_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) chk (
   .mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_data(io_data), .io_wr_n(io_wr_n),
   .sys_reset_out(sys_reset_out), .irq15_out(irq15_out), .led_out(led_out),
   .wdt_active(wdt_active));
`default_nettype wire

// [tb/wdt_host_model.sv]
// Purpose: Host model writing the watchdog port
// Assumes: Driven on falling mclk edges
// Notes: Caller paces refreshes
`timescale 1ns/1ps
`default_nettype none
module wdt_host_model
   import wdt_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Host write port
   output logic [IO_ADDR_W-1:0] io_addr,
   output logic [IO_DATA_W-1:0] io_data,
   output logic io_wr_n
);
   initial begin
      io_addr = 16'h0000;
      io_data = 8'h00;
      io_wr_n = 1'b1;
   end
   // Bus floats to inverted junk once its hold has run out
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      io_addr <= a;
      io_data <= d;
      io_wr_n <= 1'b0;
      repeat (5) @(negedge mclk);
      io_wr_n <= 1'b1;
      repeat (8) @(negedge mclk);
      io_addr <= ~a;
      io_data <= ~d;
   endtask
endmodule
`default_nettype wire

// [tb/tb_io_port_watchdog_timer.sv]
// Purpose: Self-checking bench of the port watchdog
// Assumes: Short tick and blink counts
// Notes: Random factors from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_io_port_watchdog_timer
   import wdt_pkg::*;
   ;
   localparam int unsigned T = 20;
   localparam int unsigned B = 4;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [IO_ADDR_W-1:0] io_addr;
   logic [IO_DATA_W-1:0] io_data;
   logic io_wr_n, sys_reset_out, irq15_out, led_out, wdt_active;
   int failures = 0;
   int n_checks = 0;
   always #10 mclk = ~mclk;
   wdt_host_model host (.mclk(mclk), .io_addr(io_addr), .io_data(io_data), .io_wr_n(io_wr_n));
   io_port_watchdog_timer #(.TICK_CYCLES(T), .BLINK_CYCLES(B)) uut (
      .mclk(mclk), .rst_n(rst_n), .io_addr(io_addr), .io_data(io_data), .io_wr_n(io_wr_n),
      .sys_reset_out(sys_reset_out), .irq15_out(irq15_out), .led_out(led_out),
      .wdt_active(wdt_active));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      give_verdict();
   end
   // Live cycles of a factor; index 0 is half a unit
   function automatic int period_of(input logic [7:0] f);
      return (f[2:0] == 3'h0) ? T : 2 * T * f[2:0];
   endfunction
   task automatic expire(input logic [7:0] f);
      int n;
      int p;
      logic prev;
      p = period_of(f);
      host.wr(CTRL_PORT_ADDR, f);
      prev = led_out;
      repeat (B) @(negedge mclk);
      check(16'(led_out !== prev), 16'h1);
      // Count includes the write cycle and the blink wait
      n = 14 + B;
      while (wdt_active === 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      check(16'(n >= p + 6 && n <= p + 18), 16'h1);
      check(16'({sys_reset_out, irq15_out}), 16'({~f[6], f[6]}));
      n = 0;
      while (sys_reset_out === 1'b1 && n < 1200) begin
         @(negedge mclk);
         n++;
      end
      check(16'(n), f[6] ? 16'h0 : 16'(RESET_PULSE_CYCLES));
      if (f[6]) begin
         check(16'(irq15_out), 16'h1);
         host.wr(CTRL_PORT_ADDR, FACTOR_DISABLE);
         check(16'({irq15_out, wdt_active}), 16'h0);
      end
   endtask
   initial begin
      int n;
      void'($urandom(11));
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      repeat (30) @(negedge mclk);
      check(16'({sys_reset_out, irq15_out, led_out, wdt_active}), 16'h0);
      host.wr(CTRL_PORT_ADDR ^ 16'(1 + $urandom_range(0, 254)), 8'h87);
      check(16'(wdt_active), 16'h0);
      for (int i = 0; i < 16; i++) begin
         expire({1'b1, i[3], 3'($urandom_range(0, 7)), i[2:0]});
      end
      for (int i = 0; i < 7; i++) begin
         host.wr(CTRL_PORT_ADDR, 8'h83);
         repeat ($urandom_range(40, 90)) @(negedge mclk);
         check(16'(wdt_active), 16'h1);
      end
      host.wr(CTRL_PORT_ADDR, 8'h80);
      n = 0;
      while (wdt_active === 1'b1 && n < 60) begin
         @(negedge mclk);
         n++;
      end
      check(16'(n >= 8 && n <= 30), 16'h1);
      repeat (1100) @(negedge mclk);
      host.wr(CTRL_PORT_ADDR, 8'hC7);
      host.wr(CTRL_PORT_ADDR, 8'(1 + $urandom_range(0, 126)));
      repeat (400) @(negedge mclk);
      check(16'({sys_reset_out, irq15_out, led_out, wdt_active}), 16'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
